/* File: rtl/cpc_pkg.sv */
package cpc_pkg;

  // Control frame register numbers
  localparam logic [2:0] CPC_ADDR_CR3 = 3'h3;
  localparam logic [2:0] CPC_ADDR_CR4 = 3'h4;
  localparam logic [2:0] CPC_ADDR_CR5 = 3'h5;

  // power_reset_rate_control field positions
  localparam int CPC_POWER_DOWN_SELECT_HI = 7;
  localparam int CPC_POWER_DOWN_SELECT_LO = 6;
  localparam int CPC_SOFT_RESET_BIT_BIT = 5;
  localparam int CPC_OSR_HI = 4;
  localparam int CPC_OSR_LO = 3;
  localparam int CPC_ASYNC_RATE_FACTOR_HI = 2;
  localparam int CPC_ASYNC_RATE_FACTOR_LO = 0;

  // frame_sync_divider_control field positions
  localparam int CPC_DIVSEL_BIT = 7;
  localparam int CPC_N_HI = 6;
  localparam int CPC_N_LO = 3;
  localparam int CPC_P_HI = 2;
  localparam int CPC_P_LO = 0;
  localparam int CPC_M_HI = 6;
  localparam int CPC_M_LO = 0;

  // Gain register sub-address and payload positions
  localparam int CPC_SUB_HI = 7;
  localparam int CPC_SUB_LO = 6;
  localparam int CPC_GAIN_HI = 5;
  localparam int CPC_GAIN_LO = 0;
  localparam logic [1:0] CPC_SUB_ADC = 2'h0;
  localparam logic [1:0] CPC_SUB_DAC = 2'h1;
  localparam logic [1:0] CPC_SUB_5C = 2'h2;
  localparam logic [1:0] CPC_SUB_5D = 2'h3;

  // Reset values
  localparam logic [1:0] CPC_POWER_DOWN_SELECT_RST = 2'h0;
  localparam logic [1:0] CPC_OSR_RST = 2'h0;
  localparam logic [2:0] CPC_ASYNC_RATE_FACTOR_RST = 3'h1;
  localparam logic [6:0] CPC_M_RST = 7'h10;
  localparam logic [3:0] CPC_N_RST = 4'h6;
  localparam logic [2:0] CPC_P_RST = 3'h0;
  localparam logic [5:0] CPC_ADC_GAIN_RST = 6'h2A;
  localparam logic [5:0] CPC_DAC_GAIN_RST = 6'h2A;
  localparam logic [5:0] CPC_R5C_RST = 6'h00;
  localparam logic [5:0] CPC_R5D_RST = 6'h00;

  // Timing
  localparam int CPC_CLK_NS = 20;
  localparam int CPC_SOFT_RST_NS = 100;
  localparam int CPC_SOFT_RST_CYC =
    (CPC_SOFT_RST_NS + CPC_CLK_NS - 1) / CPC_CLK_NS;
  localparam logic [4:0] CPC_FS_PRESCALE = 5'h10;
  localparam logic [1:0] CPC_UPD_PERIODS = 2'h2;

  typedef enum logic [1:0]
  {
    CPC_OSR_128 = 2'b00,
    CPC_OSR_256 = 2'b01,
    CPC_OSR_512 = 2'b10
  } cpc_osr_e;

  typedef enum logic [1:0]
  {
    CPC_RD5_ADC = 2'b00,
    CPC_RD5_DAC = 2'b01,
    CPC_RD5_5C  = 2'b10,
    CPC_RD5_5D  = 2'b11
  } cpc_rd5_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } cpc_req_s;

  typedef struct packed {
    logic       adc_pdn;
    logic       dac_pdn;
    logic       dev_pdn;
    cpc_osr_e   dac_oversample_ratio;
    logic [3:0] async_n;
    logic [7:0] m_val;
    logic [4:0] n_val;
    logic [3:0] p_val;
    logic       coarse;
    logic [5:0] adc_gain;
    logic [5:0] dac_gain;
  } cpc_ctrl_s;

endpackage : cpc_pkg

/* File: rtl/cpc_modcnt.sv */
`timescale 1ns/1ns
`default_nettype none
module cpc_modcnt
  import cpc_pkg::*;
#(
  parameter int W = 8
)
(
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  input  wire logic         i_ce,
  // Count control
  input  wire logic         i_clr,
  input  wire logic         i_inc,
  input  wire logic [W-1:0] i_limit,
  // Terminal count
  output logic              o_wrap
);

  logic [W-1:0] cnt_q;
  wire          at_last;

  // Greater-or-equal so a limit lowered mid-count still wraps at once
  assign at_last = (cnt_q >= (i_limit - W'(1)));
  assign o_wrap  = i_inc && at_last;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      cnt_q <= '0;
    else if (i_ce)
    begin
      if (i_clr || o_wrap)
        cnt_q <= '0;
      else if (i_inc)
        cnt_q <= cnt_q + W'(1);
    end
  end

endmodule : cpc_modcnt
`default_nettype wire

/* File: rtl/cpc_fs_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module cpc_fs_gen
  import cpc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_ce,
  input  wire logic       i_clr,
  // Decoded divider values
  input  wire logic [7:0] i_m_val,
  input  wire logic [4:0] i_n_val,
  input  wire logic [3:0] i_p_val,
  // Frame sync strobe
  output logic            o_fs
);

  wire pre_wrap;
  wire m_wrap;
  wire n_wrap;

  // Cascade keeps each counter narrow instead of one 19-bit divisor
  cpc_modcnt #(.W(5)) u_pre
  (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_clr     (i_clr),
    .i_inc     (1'b1),
    .i_limit   (CPC_FS_PRESCALE),
    .o_wrap    (pre_wrap)
  );

  cpc_modcnt #(.W(8)) u_m
  (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_clr     (i_clr),
    .i_inc     (pre_wrap),
    .i_limit   (i_m_val),
    .o_wrap    (m_wrap)
  );

  cpc_modcnt #(.W(5)) u_n
  (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_clr     (i_clr),
    .i_inc     (m_wrap),
    .i_limit   (i_n_val),
    .o_wrap    (n_wrap)
  );

  cpc_modcnt #(.W(4)) u_p
  (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_clr     (i_clr),
    .i_inc     (n_wrap),
    .i_limit   (i_p_val),
    .o_wrap    (o_fs)
  );

endmodule : cpc_fs_gen
`default_nettype wire

/* File: rtl/cpc_regs.sv */
// Function
// - Power-down field: 00 none, 01 ADC, 10 DAC, 11 whole device.
// - Writing 1 to bit D5 of register 3 resets the device.
// - Oversampling field: X1 gives 512, 10 gives 256, 00 gives 128.
// - Rate factor codes 1 to 7 mean 1 to 7, 000 means 8.
// - Rate factor applies only when the two channels differ in rate.
// - Register 4 write with top bit 0 loads P and N.
// - Register 4 write with top bit 1 loads M only.
// - Frame sync is master clock over 16 times M, N and P.
// - M code zero means 128, others decode directly.
// - N code zero means 16, others decode directly.
// - P code zero means 8, others decode directly.
// - New divider values reach the divider after two sample periods.
// - Register 4 reads return N and P first, then M.
// - Divider resets to M 16, N 6, P 8.
// - P equal to 8 selects coarse mode, otherwise fine mode.
// - Register 5 write with top bits 00 loads the ADC gain.
// - ADC gain code resets to 101010, the 0 dB setting.
// - Register 5 reads return ADC, DAC, 5C, then 5D contents.
`timescale 1ns/1ns
`default_nettype none
module cpc_regs
  import cpc_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_ce,
  // Register access from the serial control port
  input  wire cpc_req_s   i_req,
  output logic [7:0]      o_rdata,
  output logic            o_rvalid,
  // Channel configuration
  input  wire logic       i_rate_differ,
  // Control outputs to the codec
  output cpc_ctrl_s       o_ctrl,
  output logic            o_fs,
  output logic            o_sample_stb,
  output logic            o_soft_rst
);

  // Stored register fields
  logic [1:0] power_down_select_q;
  logic [1:0] osr_q;
  logic [2:0] async_rate_factor_q;
  logic [6:0] m_code_q;
  logic [3:0] n_code_q;
  logic [2:0] p_code_q;
  logic [5:0] adc_gain_q;
  logic [5:0] dac_gain_q;
  logic [5:0] r5c_q;
  logic [5:0] r5d_q;

  // Divider values in use by the frame sync generator
  logic [6:0] m_act_q;
  logic [3:0] n_act_q;
  logic [2:0] p_act_q;
  logic       upd_pend_q;
  logic [1:0] upd_cnt_q;

  // Soft reset sequencing
  localparam logic [3:0] SRST_LAST = 4'(CPC_SOFT_RST_CYC - 1);
  logic       srst_q;
  logic [3:0] srst_cnt_q;

  // Read sequencing
  logic       rd4_m_q;
  cpc_rd5_e   rd5_q;
  cpc_rd5_e   rd5_d;
  logic [7:0] rdata_q;
  logic       rvalid_q;
  cpc_ctrl_s  ctrl_q;
  cpc_ctrl_s  ctrl_d;

  // Access decode
  wire        wr_ok;
  wire        wr3;
  wire        wr4;
  wire        wr5;
  wire        rd3;
  wire        rd4;
  wire        rd5;
  wire        div_sel_m;
  wire [1:0]  sub_sel;
  wire [5:0]  gain_wr;
  wire        srst_done;
  wire        srst_start;

  // Writes are dropped while the internal reset runs
  assign wr_ok = i_req.wr && !srst_q;
  assign wr3   = wr_ok && (i_req.addr == CPC_ADDR_CR3);
  assign wr4   = wr_ok && (i_req.addr == CPC_ADDR_CR4);
  assign wr5   = wr_ok && (i_req.addr == CPC_ADDR_CR5);
  assign rd3   = i_req.rd && (i_req.addr == CPC_ADDR_CR3);
  assign rd4   = i_req.rd && (i_req.addr == CPC_ADDR_CR4);
  assign rd5   = i_req.rd && (i_req.addr == CPC_ADDR_CR5);

  assign div_sel_m = i_req.wdata[CPC_DIVSEL_BIT];
  assign sub_sel   = i_req.wdata[CPC_SUB_HI:CPC_SUB_LO];
  assign gain_wr   = i_req.wdata[CPC_GAIN_HI:CPC_GAIN_LO];

  assign srst_start = wr3 && i_req.wdata[CPC_SOFT_RESET_BIT_BIT];
  assign srst_done  = srst_q && (srst_cnt_q == SRST_LAST);

  // Decoded values
  wire [7:0] m_dec;
  wire [4:0] n_dec;
  wire [3:0] p_dec;
  wire [3:0] async_rate_factor_dec;
  wire [3:0] rate_div;
  wire       fs_pulse;

  assign m_dec = (m_act_q == 7'h00) ? 8'h80 : {1'b0, m_act_q};
  assign n_dec = (n_act_q == 4'h0) ? 5'h10 : {1'b0, n_act_q};
  assign p_dec = (p_act_q == 3'h0) ? 4'h8 : {1'b0, p_act_q};
  assign async_rate_factor_dec = (async_rate_factor_q == 3'h0) ? 4'h8 : {1'b0, async_rate_factor_q};
  assign rate_div = i_rate_differ ? async_rate_factor_dec : 4'h1;

  // Soft reset pulse and self-clearing bit
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      srst_q     <= 1'b0;
      srst_cnt_q <= 4'h0;
    end
    else if (i_ce)
    begin
      if (srst_start)
      begin
        srst_q     <= 1'b1;
        srst_cnt_q <= 4'h0;
      end
      else if (srst_done)
        srst_q <= 1'b0;
      else if (srst_q)
        srst_cnt_q <= srst_cnt_q + 4'h1;
    end
  end

  // Control register 3 fields; soft reset restores the defaults
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst || (i_ce && srst_q))
    begin
      power_down_select_q <= CPC_POWER_DOWN_SELECT_RST;
      osr_q  <= CPC_OSR_RST;
      async_rate_factor_q <= CPC_ASYNC_RATE_FACTOR_RST;
    end
    else if (i_ce && wr3 && !srst_start)
    begin
      power_down_select_q <= i_req.wdata[CPC_POWER_DOWN_SELECT_HI:CPC_POWER_DOWN_SELECT_LO];
      osr_q  <= i_req.wdata[CPC_OSR_HI:CPC_OSR_LO];
      async_rate_factor_q <= i_req.wdata[CPC_ASYNC_RATE_FACTOR_HI:CPC_ASYNC_RATE_FACTOR_LO];
    end
  end

  // Divider codes as written
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst || (i_ce && srst_q))
    begin
      m_code_q <= CPC_M_RST;
      n_code_q <= CPC_N_RST;
      p_code_q <= CPC_P_RST;
    end
    else if (i_ce && wr4)
    begin
      if (div_sel_m)
        m_code_q <= i_req.wdata[CPC_M_HI:CPC_M_LO];
      else
      begin
        n_code_q <= i_req.wdata[CPC_N_HI:CPC_N_LO];
        p_code_q <= i_req.wdata[CPC_P_HI:CPC_P_LO];
      end
    end
  end

  // Staged update: the divider is never retuned mid-frame
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst || (i_ce && srst_q))
    begin
      m_act_q    <= CPC_M_RST;
      n_act_q    <= CPC_N_RST;
      p_act_q    <= CPC_P_RST;
      upd_pend_q <= 1'b0;
      upd_cnt_q  <= 2'h0;
    end
    else if (i_ce)
    begin
      if (wr4)
      begin
        upd_pend_q <= 1'b1;
        upd_cnt_q  <= 2'h0;
      end
      else if (upd_pend_q && o_sample_stb)
      begin
        if (upd_cnt_q == (CPC_UPD_PERIODS - 2'h1))
        begin
          m_act_q    <= m_code_q;
          n_act_q    <= n_code_q;
          p_act_q    <= p_code_q;
          upd_pend_q <= 1'b0;
          upd_cnt_q  <= 2'h0;
        end
        else
          upd_cnt_q <= upd_cnt_q + 2'h1;
      end
    end
  end

  // Gain sub-registers
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst || (i_ce && srst_q))
    begin
      adc_gain_q <= CPC_ADC_GAIN_RST;
      dac_gain_q <= CPC_DAC_GAIN_RST;
      r5c_q      <= CPC_R5C_RST;
      r5d_q      <= CPC_R5D_RST;
    end
    else if (i_ce && wr5)
    begin
      case (sub_sel)
        CPC_SUB_ADC: adc_gain_q <= gain_wr;
        CPC_SUB_DAC: dac_gain_q <= gain_wr;
        CPC_SUB_5C:  r5c_q      <= gain_wr;
        default:     r5d_q      <= gain_wr;
      endcase
    end
  end

  // Register 5 read pointer advance
  always_comb
  begin
    case (rd5_q)
      CPC_RD5_ADC: rd5_d = CPC_RD5_DAC;
      CPC_RD5_DAC: rd5_d = CPC_RD5_5C;
      CPC_RD5_5C:  rd5_d = CPC_RD5_5D;
      CPC_RD5_5D:  rd5_d = CPC_RD5_ADC;
      default:     rd5_d = CPC_RD5_ADC;
    endcase
  end

  // Read pointers
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst || (i_ce && srst_q))
    begin
      rd4_m_q <= 1'b0;
      rd5_q   <= CPC_RD5_ADC;
    end
    else if (i_ce)
    begin
      if (wr4)
        rd4_m_q <= 1'b0;
      else if (rd4)
        rd4_m_q <= !rd4_m_q;
      if (wr5)
        rd5_q <= CPC_RD5_ADC;
      else if (rd5)
        rd5_q <= rd5_d;
    end
  end

  // Read data selection
  wire [7:0] rd3_word;
  wire [7:0] rd4_word;
  wire [7:0] rd5_word;
  wire [7:0] rd_word;

  assign rd3_word = {power_down_select_q, srst_q, osr_q, async_rate_factor_q};
  assign rd4_word = rd4_m_q ? {1'b1, m_code_q}
                            : {1'b0, n_code_q, p_code_q};
  assign rd5_word = (rd5_q == CPC_RD5_ADC) ? {CPC_SUB_ADC, adc_gain_q} :
                    (rd5_q == CPC_RD5_DAC) ? {CPC_SUB_DAC, dac_gain_q} :
                    (rd5_q == CPC_RD5_5C)  ? {CPC_SUB_5C, r5c_q} :
                                             {CPC_SUB_5D, r5d_q};
  // Unmapped registers read as zero
  assign rd_word = rd3 ? rd3_word :
                   rd4 ? rd4_word :
                   rd5 ? rd5_word : 8'h00;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else if (i_ce)
    begin
      rvalid_q <= i_req.rd;
      if (i_req.rd)
        rdata_q <= rd_word;
    end
  end

  // Decoded control word
  always_comb
  begin
    ctrl_d          = '0;
    ctrl_d.adc_pdn  = (power_down_select_q == 2'b01) || (power_down_select_q == 2'b11);
    ctrl_d.dac_pdn  = (power_down_select_q == 2'b10) || (power_down_select_q == 2'b11);
    ctrl_d.dev_pdn  = (power_down_select_q == 2'b11);
    if (osr_q[0])
      ctrl_d.dac_oversample_ratio = CPC_OSR_512;
    else if (osr_q[1])
      ctrl_d.dac_oversample_ratio = CPC_OSR_256;
    else
      ctrl_d.dac_oversample_ratio = CPC_OSR_128;
    ctrl_d.async_n  = rate_div;
    ctrl_d.m_val    = m_dec;
    ctrl_d.n_val    = n_dec;
    ctrl_d.p_val    = p_dec;
    ctrl_d.coarse   = (p_dec == 4'h8);
    ctrl_d.adc_gain = adc_gain_q;
    ctrl_d.dac_gain = dac_gain_q;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      ctrl_q <= '0;
    else if (i_ce)
      ctrl_q <= ctrl_d;
  end

  // Frame sync from the master clock
  cpc_fs_gen u_fs
  (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_clr     (srst_q),
    .i_m_val   (m_dec),
    .i_n_val   (n_dec),
    .i_p_val   (p_dec),
    .o_fs      (fs_pulse)
  );

  // Sample strobe is frame sync divided by n when channels differ
  cpc_modcnt #(.W(4)) u_rate
  (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_clr     (srst_q),
    .i_inc     (fs_pulse),
    .i_limit   (rate_div),
    .o_wrap    (o_sample_stb)
  );

  assign o_fs       = fs_pulse;
  assign o_rdata    = rdata_q;
  assign o_rvalid   = rvalid_q;
  assign o_ctrl     = ctrl_q;
  assign o_soft_rst = srst_q;

endmodule : cpc_regs
`default_nettype wire

/* File: verification/cpc_regs_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module cpc_regs_checker
  import cpc_pkg::*;
(
  // Watched ports of the register block
  input wire logic       i_clk_sys,
  input wire logic       i_nrst,
  input wire logic       i_ce,
  input wire cpc_req_s   i_req,
  input wire logic [7:0] o_rdata,
  input wire logic       o_rvalid,
  input wire logic       i_rate_differ,
  input wire cpc_ctrl_s  o_ctrl,
  input wire logic       o_fs,
  input wire logic       o_sample_stb,
  input wire logic       o_soft_rst
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  // Periods that overlap a reload, a reset, a freeze or a whole-device power-down are
  // skipped: the active values only show one clock after the load
  wire [18:0] period = 19'd16 * o_ctrl.m_val * o_ctrl.n_val * o_ctrl.p_val;
  int   gap_q;
  logic seen_q;
  logic skip_q;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst || (o_fs && i_ce))
    begin
      gap_q  <= 1;
      seen_q <= i_nrst;
      skip_q <= 1'b0;
    end
    else
    begin
      gap_q  <= gap_q + 1;
      skip_q <= skip_q | !i_ce | o_soft_rst | o_ctrl.dev_pdn |
                !$stable({o_ctrl.m_val, o_ctrl.n_val, o_ctrl.p_val});
    end
  end

  chk_read_answer: assert property (i_ce && i_req.rd |=> o_rvalid)
    else $error("read not answered next cycle");
  chk_rvalid_cause: assert property (o_rvalid |-> $past(i_req.rd))
    else $error("read valid without a read");
  chk_coarse_mode: assert property (
    o_ctrl.coarse == (o_ctrl.p_val == 4'h8))
    else $error("coarse flag does not follow P");
  chk_soft_length: assert property (
    $rose(o_soft_rst) |-> o_soft_rst [*5] ##1 !o_soft_rst)
    else $error("soft reset length wrong");
  chk_soft_cause: assert property (
    $rose(o_soft_rst) |-> $past(i_req.wr) && $past(i_req.addr) == 3'h3
    && $past(i_req.wdata[CPC_SOFT_RESET_BIT_BIT]))
    else $error("soft reset without a request");
  chk_stb_on_fs: assert property (o_sample_stb |-> o_fs)
    else $error("sample strobe off a frame sync");
  chk_rate_same: assert property (
    $past(i_nrst) && $past(i_nrst, 2) && !$past(i_rate_differ)
    |-> o_ctrl.async_n == 4'h1)
    else $error("rate factor used with equal rates");
  chk_adc_gain: assert property (
    i_ce && i_req.wr && i_req.addr == CPC_ADDR_CR5 && i_req.wdata[7:6] == 2'b00
    && !o_soft_rst |-> ##2 o_ctrl.adc_gain == $past(i_req.wdata[5:0], 2))
    else $error("adc gain write not applied");
  chk_fs_period: assert property (
    o_fs && i_ce && seen_q && !skip_q |-> gap_q == period)
    else $error("frame sync period wrong");
endmodule : cpc_regs_checker
`default_nettype wire

/* File: verification/cpc_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cpc_host_model
  import cpc_pkg::*;
(
  // Clock
  input  wire logic       i_clk_sys,
  // Read answer
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  // Request to the register block
  output cpc_req_s        o_req
);
  initial o_req = '0;

  // Idle data is inverted so a late capture never sees stale write data
  task automatic access(input logic wr, input logic [2:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rdata,
                        output logic ok);
    int n;
    @(negedge i_clk_sys);
    o_req = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
    @(negedge i_clk_sys);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: addr, wdata: ~wdata};
    ok = wr;
    rdata = 8'h00;
    for (n = 0; n < 3 && !ok; n++)
    begin
      ok = i_rvalid;
      rdata = i_rdata;
      if (!ok)
        @(negedge i_clk_sys);
    end
  endtask : access
endmodule : cpc_host_model
`default_nettype wire

/* File: verification/test_cpc_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module test_cpc_regs;
  import cpc_pkg::*;
  logic       i_clk_sys;
  logic       i_nrst;
  logic       i_ce;
  logic       i_rate_differ;
  cpc_req_s   req;
  logic [7:0] o_rdata;
  logic       o_rvalid;
  cpc_ctrl_s  o_ctrl;
  logic       o_fs;
  logic       o_sample_stb;
  logic       o_soft_rst;
  int         fail_count;
  int         compares;
  logic [7:0] rd;
  logic       ok;

`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("unexpected %0t got %0h want %0h", $time, got, exp); \
    end \
  end

  cpc_regs u_cpc_regs (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce), .i_req(req),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_rate_differ(i_rate_differ),
    .o_ctrl(o_ctrl), .o_fs(o_fs), .o_sample_stb(o_sample_stb),
    .o_soft_rst(o_soft_rst));
  cpc_host_model u_cpc_host_model (
    .i_clk_sys(i_clk_sys), .i_rdata(o_rdata), .i_rvalid(o_rvalid),
    .o_req(req));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  task automatic close_out();
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  function automatic int dec(input int c, input int z);
    return (c == 0) ? z : c;
  endfunction : dec

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_cpc_host_model.access(1'b1, a, d, rd, ok);
    @(negedge i_clk_sys);
  endtask : wr

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    u_cpc_host_model.access(1'b0, a, 8'h00, rd, ok);
    `CHK(ok, 1'b1)
    `CHK(rd, exp)
  endtask : rd_chk

  // Returns the clocks up to the next frame sync or sample strobe
  task automatic wait_pulse(input logic use_fs, output int n);
    for (n = 1; n <= 40000; n++)
    begin
      @(negedge i_clk_sys);
      if (use_fs ? o_fs : o_sample_stb)
        return;
    end
    fail_count++;
    close_out();
  endtask : wait_pulse

  task automatic t_defaults();
    `CHK(o_ctrl.m_val, 8'h10)
    `CHK(o_ctrl.n_val, 5'h06)
    `CHK(o_ctrl.p_val, 4'h8)
    `CHK(o_ctrl.coarse, 1'b1)
    `CHK(o_ctrl.dac_oversample_ratio, CPC_OSR_128)
    `CHK(o_ctrl.adc_gain, 6'h2A)
    rd_chk(CPC_ADDR_CR3, 8'h01);
    rd_chk(CPC_ADDR_CR4, 8'h30);
    rd_chk(CPC_ADDR_CR4, 8'h90);
    rd_chk(CPC_ADDR_CR5, 8'h2A);
    rd_chk(CPC_ADDR_CR5, 8'h6A);
    rd_chk(CPC_ADDR_CR5, 8'h80);
    rd_chk(CPC_ADDR_CR5, 8'hC0);
    rd_chk(3'h6, 8'h00);
  endtask : t_defaults

  task automatic t_divider();
    logic [7:0] np [5] = '{8'h09, 8'h08, 8'h01, 8'h09, 8'h09};
    logic [7:0] mc [5] = '{8'h81, 8'h81, 8'h81, 8'h80, 8'h81};
    int i, n, m, nn, p;
    int pm = 16;
    int pn = 6;
    int pp = 8;
    for (i = 0; i < 5; i++)
    begin
      wr(CPC_ADDR_CR4, np[i]);
      wr(CPC_ADDR_CR4, mc[i]);
      rd_chk(CPC_ADDR_CR4, np[i]);
      rd_chk(CPC_ADDR_CR4, mc[i]);
      wait_pulse(1'b0, n);
      repeat (2) @(negedge i_clk_sys);
      `CHK(o_ctrl.m_val * o_ctrl.n_val * o_ctrl.p_val, pm * pn * pp)
      wait_pulse(1'b0, n);
      repeat (2) @(negedge i_clk_sys);
      m = dec(mc[i][6:0], 128);
      nn = dec(np[i][6:3], 16);
      p = dec(np[i][2:0], 8);
      `CHK(o_ctrl.m_val, m[7:0])
      `CHK(o_ctrl.n_val, nn[4:0])
      `CHK(o_ctrl.p_val, p[3:0])
      `CHK(o_ctrl.coarse, p == 8)
      wait_pulse(1'b1, n);
      wait_pulse(1'b1, n);
      `CHK(n, 16 * m * nn * p)
      pm = m;
      pn = nn;
      pp = p;
    end
  endtask : t_divider

  task automatic t_ctrl3();
    int i, n;
    logic [7:0] d;
    logic [1:0] eo;
    i_rate_differ = 1'b1;
    for (i = 0; i < 8; i++)
    begin
      d = {i[1:0], 1'b0, i[1:0], i[2:0]};
      wr(CPC_ADDR_CR3, d);
      `CHK(o_ctrl.async_n, (i == 0) ? 4'h8 : i[3:0])
      eo = i[0] ? CPC_OSR_512 : (i[1] ? CPC_OSR_256 : CPC_OSR_128);
      `CHK(o_ctrl.dac_oversample_ratio, eo)
      `CHK(o_ctrl.dev_pdn, i[1:0] == 2'b11)
      `CHK({o_ctrl.adc_pdn, o_ctrl.dac_pdn}, {i[0], i[1]})
      rd_chk(CPC_ADDR_CR3, d);
    end
    wr(CPC_ADDR_CR3, 8'h03);
    wait_pulse(1'b0, n);
    wait_pulse(1'b0, n);
    `CHK(n, 48)
    i_rate_differ = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    `CHK(o_ctrl.async_n, 4'h1)
    wait_pulse(1'b0, n);
    wait_pulse(1'b0, n);
    `CHK(n, 16)
  endtask : t_ctrl3

  task automatic t_gain();
    wr(CPC_ADDR_CR5, 8'h15);
    `CHK(o_ctrl.adc_gain, 6'h15)
    rd_chk(CPC_ADDR_CR5, 8'h15);
    wr(CPC_ADDR_CR5, 8'h7F);
    `CHK({o_ctrl.adc_gain, o_ctrl.dac_gain}, {6'h15, 6'h3F})
    rd_chk(CPC_ADDR_CR5, 8'h15);
    rd_chk(CPC_ADDR_CR5, 8'h7F);
    wr(CPC_ADDR_CR5, 8'hA5);
    wr(CPC_ADDR_CR5, 8'hD3);
    rd_chk(CPC_ADDR_CR5, 8'h15);
    rd_chk(CPC_ADDR_CR5, 8'h7F);
    rd_chk(CPC_ADDR_CR5, 8'hA5);
    rd_chk(CPC_ADDR_CR5, 8'hD3);
  endtask : t_gain

  task automatic t_soft();
    int n;
    rd_chk(CPC_ADDR_CR4, 8'h09);
    u_cpc_host_model.access(1'b1, CPC_ADDR_CR3, 8'hBA, rd, ok);
    `CHK(o_soft_rst, 1'b1)
    u_cpc_host_model.access(1'b1, CPC_ADDR_CR5, 8'h00, rd, ok);
    for (n = 0; n < 10 && o_soft_rst !== 1'b0; n++)
      @(negedge i_clk_sys);
    if (n == 10)
    begin
      fail_count++;
      close_out();
    end
    repeat (2) @(negedge i_clk_sys);
    `CHK(o_ctrl.m_val, 8'h10)
    `CHK(o_ctrl.n_val, 5'h06)
    `CHK(o_ctrl.p_val, 4'h8)
    `CHK(o_ctrl.adc_gain, 6'h2A)
    rd_chk(CPC_ADDR_CR3, 8'h01);
    rd_chk(CPC_ADDR_CR4, 8'h30);
  endtask : t_soft

  task automatic t_hard();
    rd_chk(CPC_ADDR_CR5, 8'h2A);
    i_nrst = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    i_nrst = 1'b1;
    rd_chk(CPC_ADDR_CR5, 8'h2A);
    // A write under a low clock enable must leave gain and pointer alone
    @(negedge i_clk_sys);
    i_ce = 1'b0;
    wr(CPC_ADDR_CR5, 8'h00);
    `CHK(o_ctrl.adc_gain, 6'h2A)
    i_ce = 1'b1;
    rd_chk(CPC_ADDR_CR5, 8'h6A);
  endtask : t_hard

  initial
  begin
    fail_count = 0;
    compares = 0;
    i_nrst = 1'b0;
    i_ce = 1'b1;
    i_rate_differ = 1'b0;
    repeat (6) @(negedge i_clk_sys);
    i_nrst = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    t_defaults();
    t_divider();
    t_ctrl3();
    t_gain();
    t_soft();
    t_hard();
    close_out();
  end
endmodule : test_cpc_regs

bind cpc_regs cpc_regs_checker u_cpc_regs_checker (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce), .i_req(i_req),
  .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_rate_differ(i_rate_differ),
  .o_ctrl(o_ctrl), .o_fs(o_fs), .o_sample_stb(o_sample_stb),
  .o_soft_rst(o_soft_rst));
`default_nettype wire
